// *** rtl/aof_defs.svh ***
// Constants for the ADC output formatter.
`ifndef AOF_DEFS_SVH
`define AOF_DEFS_SVH
`define AOF_WORD_W 10
`define AOF_RATIO_1 2'b01
`define AOF_RATIO_2 2'b11
`define AOF_RATIO_4 2'b10
`define AOF_RATIO_NONE 2'b00
`define AOF_TEST_NORMAL 2'b11
`define AOF_TEST_ZERO 2'b01
`define AOF_TEST_ONE 2'b10
`define AOF_TEST_CHECK 2'b00
`define AOF_CHECK_EVEN 10'h155
`define AOF_CHECK_ODD 10'h2aa
`define AOF_ALL_ZERO 10'h000
`define AOF_ALL_ONE 10'h3ff
`define AOF_DECIM_LAST 3'h7
`define AOF_SLOT_A 2'h0
`define AOF_SLOT_B 2'h1
`define AOF_SLOT_C 2'h2
`define AOF_SLOT_D 2'h3
`define AOF_LAST_1 2'h0
`define AOF_LAST_2 2'h1
`define AOF_LAST_4 2'h3
`define AOF_NPORT 4
`endif

// *** rtl/aof_pkg.sv ***
// Types shared by the ADC output formatter modules.
package aof_pkg;
  typedef logic [9:0] aof_word_t;
  typedef enum logic [1:0]
  {
    AOF_ST_RESET = 2'b00,
    AOF_ST_RUN = 2'b01
  } aof_state_t;
endpackage

// *** rtl/aof_lane_if.sv ***
// Interface carrying one group of words from the distributor to the port bank.
`timescale 1ns/100ps
interface aof_lane_if;
  logic [39:0] words;
  logic load;
  logic clear;
  modport src (output words, output load, output clear);
  modport dst (input words, input load, input clear);
endinterface

// *** rtl/aof_port_bank.sv ***
// Output registers of the four ports, all loaded on one edge.
`timescale 1ns/100ps
`include "aof_defs.svh"
module aof_port_bank
  import aof_pkg::*;
(
  // Clock.
  input wire logic clk_i,
  // Group of words.
  aof_lane_if.dst lane,
  // Port data.
  output logic [39:0] ports_o
);
  // One generate loop keeps the four ports updating together.
  // Each port owns its register, so no variable has more than one clocked writer.
  genvar g;
  generate
    for (g = 0; g < `AOF_NPORT; g = g + 1)
    begin : g_port
      aof_word_t port_word;
      always_ff @(posedge clk_i)
      begin
        if (lane.clear)
          port_word <= `AOF_ALL_ZERO;
        else if (lane.load)
          port_word <= lane.words[g*`AOF_WORD_W +: `AOF_WORD_W];
      end
      assign ports_o[g*`AOF_WORD_W +: `AOF_WORD_W] = port_word;
    end
  endgenerate
endmodule

// *** rtl/aof_formatter.sv ***
// ADC output demultiplexer, test pattern generator and decimator.
// Operation
// - Ratio code picks one, two or four ports.
// - Samples go round-robin starting at port A.
// - All active ports update together.
// - Test code selects normal, zeros or ones.
// - Code 00 gives alternating checkerboard words.
// - Checkerboard starts with port A word.
// - Active-low external reset resynchronises logic.
// - Power-up reset orders output words.
// - Decimation forwards one of eight samples.
// - Decimation combines with demultiplex ratio.
// - Decimate enable is active low.
// - Delay tune enable is active low.
// - Strobe toggles once per group.
// - Ports carry ten bits, bit 0 LSB.
// - External reset acts on the next clock edge.
// - Control inputs have no pull-ups; tie them high for the defaults.
`timescale 1ns/100ps
`include "aof_defs.svh"
module aof_formatter
  import aof_pkg::*;
(
  // Clock and resets.
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic EXT_RESET_N_I,
  // Static controls; tie high for the default modes.
  input wire logic RATIO_SEL_LO_I,
  input wire logic RATIO_SEL_HI_I,
  input wire logic TEST_SEL_LO_I,
  input wire logic TEST_SEL_HI_I,
  input wire logic DECIMATE_EN_N_I,
  input wire logic DELAY_TUNE_EN_N_I,
  // Converted samples.
  input wire logic [9:0] SAMPLE_I,
  // Output ports and strobe.
  output logic [9:0] PORT_A_O,
  output logic [9:0] PORT_B_O,
  output logic [9:0] PORT_C_O,
  output logic [9:0] PORT_D_O,
  output logic WORD_STROBE_P_O,
  output logic WORD_STROBE_N_O,
  output logic DELAY_TUNE_ACTIVE_O
);
  aof_lane_if lane ();
  aof_state_t state;
  aof_state_t next_state;
  logic [2:0] decim_cnt;
  logic [1:0] slot;
  logic [29:0] gather;
  logic check_phase;
  logic strobe;
  logic [39:0] ports;
  wire [1:0] ratio = {RATIO_SEL_HI_I, RATIO_SEL_LO_I};
  wire [1:0] test = {TEST_SEL_HI_I, TEST_SEL_LO_I};
  // External reset is folded in combinationally but only takes effect on the next clock edge.
  wire rst = SYS_RST_I | ~EXT_RESET_N_I;
  // Decode of the ratio; code 00 is unused and falls back to one port.
  wire [1:0] last_slot = (ratio == `AOF_RATIO_4) ? `AOF_LAST_4 :
                         (ratio == `AOF_RATIO_2) ? `AOF_LAST_2 : `AOF_LAST_1;
  wire decim_on = ~DECIMATE_EN_N_I;
  wire take = ~decim_on | (decim_cnt == `AOF_DECIM_LAST);
  // Test pattern word; checkerboard phase toggles on every taken word and never restarts per group.
  wire aof_word_t check_word = check_phase ? `AOF_CHECK_ODD : `AOF_CHECK_EVEN;
  wire aof_word_t word = (test == `AOF_TEST_ZERO) ? `AOF_ALL_ZERO :
                         (test == `AOF_TEST_ONE) ? `AOF_ALL_ONE :
                         (test == `AOF_TEST_CHECK) ? check_word : SAMPLE_I;
  wire group_done = take & (slot == last_slot);
  wire running = (state == AOF_ST_RUN);

  // One idle cycle after any reset before the first sample is taken.
  // Leaving the idle state only through the clocked register gives the slot pointer
  // and the decimation counter a known starting point after either reset.
  always_comb
  begin
    next_state = state;
    unique case (state)
      AOF_ST_RESET: next_state = AOF_ST_RUN;
      AOF_ST_RUN: next_state = AOF_ST_RUN;
      // The two spare codes are illegal; fall back to the idle state.
      default: next_state = AOF_ST_RESET;
    endcase
  end
  always_ff @(posedge CLK_I)
  begin
    if (rst)
      state <= AOF_ST_RESET;
    else
      state <= next_state;
  end

  // Decimation counter runs on every sample so the kept one is regular.
  always_ff @(posedge CLK_I)
  begin
    if (rst | ~running)
      decim_cnt <= 3'h0;
    else
      decim_cnt <= decim_cnt + 3'h1;
  end

  // Round-robin slot pointer and staging of words A to C.
  always_ff @(posedge CLK_I)
  begin
    if (rst | ~running)
    begin
      slot <= `AOF_SLOT_A;
      gather <= 30'h0;
      check_phase <= 1'b0;
    end
    else if (take)
    begin
      slot <= group_done ? `AOF_SLOT_A : slot + 2'h1;
      check_phase <= ~check_phase;
      if (slot != `AOF_SLOT_D)
        gather[slot*10 +: 10] <= word;
    end
  end

  // Whole group goes out on one edge; strobe toggles per group.
  always_ff @(posedge CLK_I)
  begin
    if (rst)
      strobe <= 1'b0;
    else if (running & group_done)
      strobe <= ~strobe;
  end

  // Width of the group decides which lanes carry data.
  wire four_on = (last_slot == `AOF_LAST_4);
  wire two_on = (last_slot == `AOF_LAST_2);
  wire one_on = (last_slot == `AOF_LAST_1);
  // Last word of the group bypasses staging, which saves a fourth staging register;
  // lanes outside the selected ratio load zeros so the receiver never sees old samples.
  wire aof_word_t lane_d = four_on ? word : `AOF_ALL_ZERO;
  wire aof_word_t lane_c = four_on ? gather[29:20] : `AOF_ALL_ZERO;
  wire aof_word_t lane_b = one_on ? `AOF_ALL_ZERO : (two_on ? word : gather[19:10]);
  wire aof_word_t lane_a = one_on ? word : gather[9:0];
  assign lane.words = {lane_d, lane_c, lane_b, lane_a};
  assign lane.load = running & group_done;
  assign lane.clear = rst;

  aof_port_bank u_bank
  (
    .clk_i(CLK_I),
    .lane(lane),
    .ports_o(ports)
  );

  // Ports are ten bits each, bit 0 least significant.
  assign PORT_A_O = ports[9:0];
  assign PORT_B_O = ports[19:10];
  assign PORT_C_O = ports[29:20];
  assign PORT_D_O = ports[39:30];
  assign WORD_STROBE_P_O = strobe;
  assign WORD_STROBE_N_O = ~strobe;
  assign DELAY_TUNE_ACTIVE_O = ~DELAY_TUNE_EN_N_I;

  // Strobe checks come first, since every downstream capture hangs on the strobe.
  strobe_on_load_a: assert property (@(posedge CLK_I) disable iff (rst)
    lane.load |=> (strobe != $past(strobe))) else $error("strobe did not toggle");
  strobe_hold_a: assert property (@(posedge CLK_I) disable iff (rst)
    !lane.load |=> $stable(strobe)) else $error("strobe moved without group");

  // Static test words on every ratio; checkerboard on the two- and four-port ratios.
  zero_test_a: assert property (@(posedge CLK_I) disable iff (rst)
    (lane.load && test == `AOF_TEST_ZERO) |=> PORT_A_O == `AOF_ALL_ZERO)
    else $error("zero test failed");
  one_test_a: assert property (@(posedge CLK_I) disable iff (rst)
    (lane.load && test == `AOF_TEST_ONE) |=> PORT_A_O == `AOF_ALL_ONE)
    else $error("ones test failed");
  check_start_a: assert property (@(posedge CLK_I) disable iff (rst)
    (lane.load && test == `AOF_TEST_CHECK && last_slot == `AOF_LAST_2) |=> PORT_A_O == `AOF_CHECK_EVEN)
    else $error("checkerboard not starting on port A");
  check_alt_a: assert property (@(posedge CLK_I) disable iff (rst)
    (lane.load && test == `AOF_TEST_CHECK && last_slot == `AOF_LAST_2) |=> PORT_B_O == `AOF_CHECK_ODD)
    else $error("checkerboard not alternating");
  check_four_a: assert property (@(posedge CLK_I) disable iff (rst)
    (lane.load && test == `AOF_TEST_CHECK && last_slot == `AOF_LAST_4) |=>
    (PORT_C_O == `AOF_CHECK_EVEN && PORT_D_O == `AOF_CHECK_ODD))
    else $error("checkerboard on ports C and D wrong");

  // Group spacing and word order for each ratio.
  ratio1_span_a: assert property (@(posedge CLK_I) disable iff (rst)
    (lane.load && !decim_on && last_slot == `AOF_LAST_1) |=> lane.load)
    else $error("one-port group spacing wrong");
  ratio2_span_a: assert property (@(posedge CLK_I) disable iff (rst)
    (lane.load && !decim_on && last_slot == `AOF_LAST_2) |=> !lane.load ##1 lane.load)
    else $error("two-port group spacing wrong");
  ratio4_span_a: assert property (@(posedge CLK_I) disable iff (rst)
    (lane.load && !decim_on && last_slot == `AOF_LAST_4) |=> !lane.load [*3] ##1 lane.load)
    else $error("four-port group spacing wrong");
  ratio2_order_a: assert property (@(posedge CLK_I) disable iff (rst)
    (lane.load && !decim_on && test == `AOF_TEST_NORMAL && last_slot == `AOF_LAST_2) |=>
    (PORT_A_O == $past(SAMPLE_I, 2) && PORT_B_O == $past(SAMPLE_I)))
    else $error("two-port word order wrong");
  ratio4_order_a: assert property (@(posedge CLK_I) disable iff (rst)
    (lane.load && !decim_on && test == `AOF_TEST_NORMAL && last_slot == `AOF_LAST_4) |=>
    (PORT_A_O == $past(SAMPLE_I, 4) && PORT_D_O == $past(SAMPLE_I)))
    else $error("four-port group not presented together");
  unused_zero_a: assert property (@(posedge CLK_I) disable iff (rst)
    (lane.load && last_slot == `AOF_LAST_2) |=>
    (PORT_C_O == `AOF_ALL_ZERO && PORT_D_O == `AOF_ALL_ZERO))
    else $error("unused ports carry data");
  decim_rate_a: assert property (@(posedge CLK_I) disable iff (rst)
    (lane.load && decim_on && last_slot == `AOF_LAST_1) |=> !lane.load [*7])
    else $error("decimation rate wrong");
  decim2_span_a: assert property (@(posedge CLK_I) disable iff (rst)
    (lane.load && decim_on && last_slot == `AOF_LAST_2) |-> ##16 lane.load)
    else $error("decimated two-port spacing wrong");

  // Resets and the static enable.
  reset_clear_a: assert property (@(posedge CLK_I)
    !EXT_RESET_N_I |=> (PORT_A_O == `AOF_ALL_ZERO && slot == `AOF_SLOT_A))
    else $error("external reset not applied");
  clear_strobe_a: assert property (@(posedge CLK_I)
    rst |=> (!WORD_STROBE_P_O && PORT_B_O == `AOF_ALL_ZERO))
    else $error("reset did not clear strobe and ports");
  tune_en_a: assert property (@(posedge CLK_I)
    DELAY_TUNE_ACTIVE_O == !DELAY_TUNE_EN_N_I) else $error("delay tune enable polarity");

  // Main scenarios.
  cov_ratio4_c: cover property (@(posedge CLK_I) lane.load && last_slot == `AOF_LAST_4);
  cov_check_c: cover property (@(posedge CLK_I) lane.load && test == `AOF_TEST_CHECK);
  cov_decim_c: cover property (@(posedge CLK_I) lane.load && decim_on);
  cov_ratio1_c: cover property (@(posedge CLK_I) lane.load && !decim_on && last_slot == `AOF_LAST_1);
  cov_reset_c: cover property (@(posedge CLK_I) !EXT_RESET_N_I ##1 EXT_RESET_N_I);
endmodule

// *** tb/aof_capture.sv ***
// Capture model of the downstream logic that latches the ports.
`timescale 1ns/100ps
module aof_capture
(
  // Clock and shared strobe.
  input wire logic clk_i,
  input wire logic strobe_i,
  // Ports packed D, C, B, A.
  input wire logic [39:0] ports_i,
  // Latest group, previous group, group count and spacing in cycles.
  output logic [39:0] words_o,
  output logic [39:0] prev_o,
  output int count_o,
  output int gap_o
);
  logic last = 1'b0;
  int cyc = 0;
  initial count_o = 0;
  // Either strobe edge latches a whole group; unused ports are kept but ignored.
  always @(posedge clk_i)
  begin
    cyc++;
    if (strobe_i !== last)
    begin
      prev_o = words_o;
      words_o = ports_i;
      gap_o = cyc;
      count_o++;
      cyc = 0;
    end
    last = strobe_i;
  end
endmodule

// *** tb/adc_output_demux_test_formatter_tb.sv ***
// Self-checking bench for the ADC output formatter.
`timescale 1ns/100ps
module adc_output_demux_test_formatter_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rst_n = 1'b1;
  logic [1:0] ratio = 2'b11;
  logic [1:0] test = 2'b11;
  logic decimate_en_n = 1'b1;
  logic tune_n = 1'b1;
  logic [9:0] smp = 10'h000;
  logic [9:0] pa, pb, pc, pd;
  logic sp, sn, tune;
  logic [39:0] w, pw;
  int cnt, gap;
  int num_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  // A counting sample stream makes port order visible.
  always #5 clk = ~clk;
  always @(posedge clk) smp <= #1 smp + 10'h001;
  // Watchdog; the whole run needs well under a thousand cycles.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      num_errors++;
      test_done;
    end
  end
  aof_formatter i_dut (.CLK_I(clk), .SYS_RST_I(rst), .EXT_RESET_N_I(rst_n), .RATIO_SEL_LO_I(ratio[0]),
    .RATIO_SEL_HI_I(ratio[1]), .TEST_SEL_LO_I(test[0]), .TEST_SEL_HI_I(test[1]), .DECIMATE_EN_N_I(decimate_en_n),
    .DELAY_TUNE_EN_N_I(tune_n), .SAMPLE_I(smp), .PORT_A_O(pa), .PORT_B_O(pb), .PORT_C_O(pc), .PORT_D_O(pd),
    .WORD_STROBE_P_O(sp), .WORD_STROBE_N_O(sn), .DELAY_TUNE_ACTIVE_O(tune));
  aof_capture i_cap (.clk_i(clk), .strobe_i(sp), .ports_i({pd, pc, pb, pa}), .words_o(w), .prev_o(pw),
    .count_o(cnt), .gap_o(gap));
  task chk(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1)
    begin
      num_errors++;
      $display("MISMATCH %0t: %s", $time, msg);
    end
  endtask
  task test_done;
    $display("Errors %0d, checks %0d", num_errors, num_checks);
    if (num_errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Waits for the next captured group; the watchdog bounds the wait.
  task grab;
    int c0;
    c0 = cnt;
    wait (cnt != c0);
    #1;
    chk(sn === ~sp, "strobe pair");
  endtask
  // A mode change made here comes with a one-cycle external reset pulse, set in the same cycle.
  task set_mode(input logic [1:0] r, input logic [1:0] t, input logic d);
    @(posedge clk);
    #1;
    ratio = r;
    test = t;
    decimate_en_n = d;
    rst_n = 1'b0;
    @(posedge clk);
    #1;
    chk(sp === 1'b0 && pa === 10'h000, "ext reset");
    rst_n = 1'b1;
    grab;
    grab;
    grab;
  endtask
  task sc_order;
    logic [1:0] codes [3] = '{2'b01, 2'b11, 2'b10};
    int n, k;
    for (int d = 0; d < 2; d++)
      for (int i = 0; i < 3; i++)
      begin
        n = 1 << i;
        k = d ? 8 : 1;
        set_mode(codes[i], 2'b11, d == 0);
        chk(gap == n * k, "group spacing");
        chk(w[9:0] === pw[9:0] + 10'(n * k), "port A stream");
        for (int j = 1; j < n; j++)
          chk(w[10 * j +: 10] === w[9:0] + 10'(j * k), "port order");
      end
    decimate_en_n = 1'b1;
  endtask
  task sc_test;
    set_mode(2'b10, 2'b01, 1'b1);
    chk(w === 40'h0, "all zeros");
    set_mode(2'b10, 2'b10, 1'b1);
    chk(w === {4{10'h3ff}}, "all ones");
    set_mode(2'b10, 2'b00, 1'b1);
    chk(w === {10'h2aa, 10'h155, 10'h2aa, 10'h155}, "checker 1:4");
    set_mode(2'b11, 2'b00, 1'b1);
    chk(w[19:0] === {10'h2aa, 10'h155}, "checker 1:2");
    set_mode(2'b01, 2'b00, 1'b1);
    chk(w[9:0] === ~pw[9:0] && (w[9:0] === 10'h155 || w[9:0] === 10'h2aa), "checker 1:1");
  endtask
  task sc_misc;
    tune_n = 1'b0;
    @(posedge clk);
    #1;
    chk(tune === 1'b1, "tune on");
    tune_n = 1'b1;
    @(posedge clk);
    #1;
    chk(tune === 1'b0, "tune off");
    ratio = 2'b10;
    test = 2'b11;
    rst = 1'b1;
    @(posedge clk);
    #1;
    chk(sp === 1'b0 && pb === 10'h000, "power-up reset");
    rst = 1'b0;
    grab;
    grab;
    grab;
    chk(gap == 4 && w[19:10] === w[9:0] + 10'h001, "order after power-up reset");
    chk(w[39:30] === w[9:0] + 10'h003, "port D after power-up reset");
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    grab;
    grab;
    chk(gap == 2, "default 1:2");
    sc_order;
    sc_test;
    sc_misc;
    test_done;
  end
endmodule
